/* File: hdl/cdt_regs.svh */
/*
  Constants for the correlator dump transfer block: word layout, timing
  counts and sizes. Assumes a 50 MHz core clock.
*/
`ifndef CDT_REGS_SVH
`define CDT_REGS_SVH

`define CDT_CLK_MHZ          50
`define CDT_WORD_W           16
`define CDT_MARK_BIT         15
`define CDT_CNT_W            20
`define CDT_ACF_W            28
`define CDT_ACF_DROP         8
`define CDT_DUMP_SEC_LONG    10
`define CDT_DUMP_SEC_SHORT   1
`define CDT_DUMP_CYC_LONG    (`CDT_DUMP_SEC_LONG * `CDT_CLK_MHZ * 1000000)
`define CDT_DUMP_CYC_SHORT   (`CDT_DUMP_SEC_SHORT * `CDT_CLK_MHZ * 1000000)
`define CDT_HI_LEN           5
`define CDT_LO_LEN           15

`endif

/* File: hdl/cdt_pkg.sv */
/*
  Types for the correlator dump transfer block.
  Assumes the constants header is compiled alongside.
*/
package cdt_pkg;
  // Word handed to the host port
  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } cdt_word_type;

  // Host read request
  typedef struct packed {
    logic        rd;
    logic        done;
  } cdt_req_type;

  typedef enum logic [2:0] {
    CDT_IDLE = 3'b001,
    CDT_HI   = 3'b010,
    CDT_LO   = 3'b100
  } cdt_state_type;
endpackage

/* File: hdl/cdt_sync.sv */
/*
  Two flip-flop synchroniser with rising-edge pulse output.
  Assumes the input comes from outside the core clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
module cdt_sync
(
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic async_in,
  output logic      level_out,
  output logic      rise_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // First stage read only by the second stage
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end
    else
    begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  assign level_out = s2_reg;
  assign rise_out  = s2_reg & ~s3_reg;
endmodule // cdt_sync
`default_nettype wire

/* File: hdl/cdt_dump.sv */
/*
  Correlator dump transfer: two counter banks, a dump timer locked to the
  observatory reference tick, and a word port the host reads at its pace.
  Assumes the counter front end writes accumulation values on acc_we, and
  the host pulses rd to take each word.
*/
`timescale 1ns/1ns
`default_nettype none
`include "cdt_regs.svh"
// Functional notes
// - Raise an interrupt pulse at every integration period end.
// - Two banks: one accumulates, the other holds the previous dump.
// - Marker bit alternates one and zero across successive words.
// - Dump timing restarts on the observatory reference clock tick.
// - First counter word per receiver is the attempt total.
// - Even words carry one in the marker bit, odd words zero.
// - Each 20-bit value goes out as two consecutive words.
// - Autocorrelation counters drop their eight low bits before sending.
// - Data-available raises when ready, drops once host took all.
module cdt_dump
#(
  parameter int DEPTH      = 64,
  parameter int AW         = 6,
  parameter int DUMP_LONG  = `CDT_DUMP_CYC_LONG,
  parameter int DUMP_SHORT = `CDT_DUMP_CYC_SHORT
)
(
  input  wire logic                 core_clk,
  input  wire logic                 rstn,
  input  wire logic                 ref_tick,
  input  wire logic                 dump_long,
  input  wire logic                 acc_we,
  input  wire logic [AW-1:0]        acc_addr,
  input  wire logic                 acc_is_acf,
  input  wire logic [27:0]          acc_val,
  input  wire cdt_pkg::cdt_req_type host_req,
  output cdt_pkg::cdt_word_type     host_word,
  output logic                      dump_irq,
  output logic                      data_avail,
  output logic                      bank_sel
);
  logic [19:0]          bank0 [DEPTH];
  logic [19:0]          bank1 [DEPTH];
  logic [31:0]          tmr_reg;
  logic                 bank_reg;
  logic                 avail_reg;
  logic                 irq_reg;
  logic [AW-1:0]        rptr_reg;
  logic                 half_reg;
  logic                 mark_reg;
  logic [15:0]          word_reg;
  logic                 valid_reg;
  logic                 long_lvl;
  logic                 tick_rise;
  wire  [31:0]          period;
  wire                  dump_end;
  wire  [19:0]          acc_sel;
  wire  [19:0]          rd_val;
  wire                  take;
  wire                  last;

  // Reference tick arrives from another clock domain
  cdt_sync u_sync
  (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .async_in  (ref_tick),
    .level_out (),
    .rise_out  (tick_rise)
  );

  // Period switch is a panel level from outside the core clock domain;
  // a change takes effect two cycles late, which no dump can notice
  cdt_sync u_long_sync
  (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .async_in  (dump_long),
    .level_out (long_lvl),
    .rise_out  ()
  );

  // Period select and end of integration
  assign period   = long_lvl ? 32'(DUMP_LONG) : 32'(DUMP_SHORT);
  assign dump_end = tick_rise | (tmr_reg >= period - 32'h1);
  // Autocorrelation counts lose their low bits; power counts keep their low twenty bits
  assign acc_sel  = acc_is_acf ? acc_val[27:8] : acc_val[19:0];
  assign rd_val   = bank_reg ? bank0[rptr_reg] : bank1[rptr_reg];
  assign take     = host_req.rd & avail_reg;
  assign last     = half_reg & (rptr_reg == AW'(DEPTH - 1));

  // Dump timer; the reference tick realigns it so dumps carry true time
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      tmr_reg <= 32'h0;
    else if (dump_end)
      tmr_reg <= 32'h0;
    else
      tmr_reg <= tmr_reg + 32'h1;
  end

  // Accumulate into the active bank; entry 0 is the attempt count
  always_ff @(posedge core_clk)
  begin
    if (acc_we && !bank_reg)
      bank0[acc_addr] <= acc_sel;
    if (acc_we && bank_reg)
      bank1[acc_addr] <= acc_sel;
  end

  // Bank swap, interrupt and read pointer; swap restarts reading, so a
  // host that is late loses the old dump by design
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      bank_reg  <= 1'b0;
      irq_reg   <= 1'b0;
      avail_reg <= 1'b0;
      rptr_reg  <= '0;
      half_reg  <= 1'b0;
      mark_reg  <= 1'b1;
    end
    else if (dump_end)
    begin
      bank_reg  <= ~bank_reg;
      irq_reg   <= 1'b1;
      avail_reg <= 1'b1;
      rptr_reg  <= '0;
      half_reg  <= 1'b0;
      mark_reg  <= 1'b1;
    end
    else
    begin
      irq_reg <= 1'b0;
      if (take)
      begin
        half_reg <= ~half_reg;
        mark_reg <= ~mark_reg;
        if (half_reg)
          rptr_reg <= rptr_reg + AW'(1);
        if (last || host_req.done)
          avail_reg <= 1'b0;
      end
      else if (host_req.done)
        avail_reg <= 1'b0;
    end
  end

  // Output word: high part first, then low part, marker in top bit
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      word_reg  <= 16'h0;
      valid_reg <= 1'b0;
    end
    else
    begin
      valid_reg <= take & ~dump_end;
      if (take)
        word_reg <= half_reg ? {mark_reg, rd_val[14:0]}
                             : {mark_reg, 10'h0, rd_val[19:15]};
    end
  end

  assign host_word.valid = valid_reg;
  assign host_word.data  = word_reg;
  assign dump_irq        = irq_reg;
  assign data_avail      = avail_reg;
  assign bank_sel        = bank_reg;

  // Checker state: marker of the last word shown, and whether this dump
  // has shown one yet; a word shown in the dump_end cycle is the old dump's
  logic chk_mark_reg;
  logic chk_seen_reg;

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      chk_mark_reg <= 1'b0;
      chk_seen_reg <= 1'b0;
    end
    else if (dump_end)
      chk_seen_reg <= 1'b0;
    else if (host_word.valid)
    begin
      chk_mark_reg <= host_word.data[15];
      chk_seen_reg <= 1'b1;
    end
  end

  // A host read that the port accepts
  sequence s_accept;
    take && !dump_end;
  endsequence

  // Marker alternates on consecutive words within a dump
  a_mark_alt: assert property (@(posedge core_clk) disable iff (!rstn)
    host_word.valid && chk_seen_reg |-> host_word.data[15] != chk_mark_reg)
    else $error("marker check");
  a_first_even: assert property (@(posedge core_clk) disable iff (!rstn)
    host_word.valid && !chk_seen_reg |-> host_word.data[15] == 1'b1)
    else $error("first word marker not one");
  a_irq_swap: assert property (@(posedge core_clk) disable iff (!rstn)
    dump_end |=> (bank_reg != $past(bank_reg)) && dump_irq)
    else $error("no swap at interrupt");
  a_irq_pulse: assert property (@(posedge core_clk) disable iff (!rstn)
    dump_irq |=> !dump_irq || $past(dump_end))
    else $error("interrupt held");
  a_avail_set: assert property (@(posedge core_clk) disable iff (!rstn)
    dump_end |=> data_avail)
    else $error("data available not raised");
  a_avail_drop: assert property (@(posedge core_clk) disable iff (!rstn)
    take && last && !dump_end |=> !data_avail)
    else $error("data available not dropped");
  a_pair_hi: assert property (@(posedge core_clk) disable iff (!rstn)
    take && !half_reg && !dump_end |=> host_word.data[14:5] == 10'h0)
    else $error("high half padding");
  a_tick_sync: assert property (@(posedge core_clk) disable iff (!rstn)
    tick_rise |=> tmr_reg == 32'h0)
    else $error("timer not realigned");
  a_word_take: assert property (@(posedge core_clk) disable iff (!rstn)
    s_accept |=> host_word.valid)
    else $error("accepted read gave no word");
  a_idle_no_word: assert property (@(posedge core_clk) disable iff (!rstn)
    !data_avail |=> !host_word.valid)
    else $error("word without data available");
  a_irq_cause: assert property (@(posedge core_clk) disable iff (!rstn)
    !dump_end |=> !dump_irq)
    else $error("interrupt without period end");
endmodule // cdt_dump
`default_nettype wire

/* File: bench/cdt_host.sv */
/*
  Host model: after each interrupt it takes the whole dump, word by word, or with quit set drops it with done.
  Assumes the bench checks the words; slow mode leaves gaps between reads.
*/
`timescale 1ns/1ns
`default_nettype none
module cdt_host
#(
  parameter int NW = 8
)
(
  input  wire logic            core_clk,
  input  wire logic            dump_irq,
  input  wire logic            data_avail,
  input  wire logic            slow,
  input  wire logic            quit,
  output cdt_pkg::cdt_req_type host_req
);
  int   cnt = NW;
  logic ph  = 1'b0;

  // Counting words keeps a stray read off the end of the dump
  always @(negedge core_clk)
  begin
    ph = ~ph;
    if (dump_irq)
      cnt = 0;
    // A quitting host drops the dump with done instead of reading it
    host_req.done = quit && data_avail;
    host_req.rd = !quit && (cnt < NW) && data_avail && (!slow || ph);
    if (host_req.rd)
      cnt = cnt + 1;
  end
endmodule // cdt_host
`default_nettype wire

/* File: bench/tb_cdt_dump.sv */
/*
  Testbench for cdt_dump: fills banks, lets the host model read them.
  Assumes short periods of 100 and 200 cycles and four entries a bank.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_cdt_dump;
  localparam int D  = 4;
  localparam int NW = 2 * D;
  logic                  core_clk, rstn, ref_tick, dump_long, acc_we, acc_is_acf, slow, quit;
  logic [1:0]            acc_addr;
  logic [27:0]           acc_val;
  cdt_pkg::cdt_req_type  host_req;
  cdt_pkg::cdt_word_type host_word;
  logic                  dump_irq, data_avail, bank_sel;
  logic [15:0]           exp_q[$];
  logic [15:0]           pend[$];
  logic [31:0]           lfsr = 32'h00014ecd;
  int                    n_fail = 0;
  int                    checks_done = 0;
  int                    cyc = 0;
  int                    t0 = 0;
  int                    irq_at[5];
  int                    n_got = 0;
  int                    sum_exp[2] = '{0, 0};
  int                    sum_got[2] = '{0, 0};
  logic [4:0]            hi5;

  cdt_dump #(.DEPTH(D), .AW(2), .DUMP_LONG(200), .DUMP_SHORT(100)) DUT (.core_clk(core_clk), .rstn(rstn),
    .ref_tick(ref_tick), .dump_long(dump_long), .acc_we(acc_we), .acc_addr(acc_addr), .acc_is_acf(acc_is_acf),
    .acc_val(acc_val), .host_req(host_req), .host_word(host_word), .dump_irq(dump_irq),
    .data_avail(data_avail), .bank_sel(bank_sel));
  cdt_host #(.NW(NW)) host (.core_clk(core_clk), .dump_irq(dump_irq), .data_avail(data_avail),
    .slow(slow), .quit(quit), .host_req(host_req));

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] expv, input string what);
    checks_done++;
    if (seen !== expv)
    begin
      n_fail++;
      $display("[FAIL] %0t %s: got %h exp %h", $time, what, seen, expv);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // One entry write; correlation counts keep their upper twenty bits
  task automatic put(input logic [1:0] a);
    logic [19:0] k;
    lfsr = nxt(lfsr);
    acc_we = 1'b1;
    acc_addr = a;
    acc_is_acf = (a == 2'(D - 1)) ? 1'b0 : lfsr[31];
    acc_val = (a == 2'(D - 1)) ? 28'(slow) : lfsr[27:0];
    k = acc_is_acf ? acc_val[27:8] : acc_val[19:0];
    sum_exp[slow] += k;
    pend.push_back({1'b1, 10'h000, k[19:15]});
    pend.push_back({1'b0, k[14:0]});
    @(negedge core_clk);
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Cycle count and hang guard
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_fail++;
      summarize();
    end
  end

  // Monitor off the launching edge; a word nobody expected counts as a mismatch
  always @(negedge core_clk)
  begin
    if (host_word.valid === 1'b1)
    begin
      check(host_word.data, exp_q.size() ? exp_q.pop_front() : 16'hxxxx, "word");
      check(host_word.data[15], n_got % 2 == 0, "marker alternation");
      if (n_got % 2 == 0)
        hi5 = host_word.data[4:0];
      else
        sum_got[(n_got / NW) % 2] += {hi5, host_word.data[14:0]};
      n_got++;
    end
  end

  initial
  begin
    rstn = 1'b0;
    ref_tick = 1'b0;
    dump_long = 1'b0;
    acc_we = 1'b0;
    acc_addr = 2'h0;
    acc_is_acf = 1'b0;
    acc_val = 28'h0000000;
    slow = 1'b0;
    quit = 1'b0;
    repeat (20) @(negedge core_clk);
    rstn = 1'b1;
    check(data_avail, 0, "avail at reset");
    for (int p = 0; p < 5; p++)
    begin
      if (p > 0)
      begin
        while (exp_q.size() != 0) @(negedge core_clk);
        check((cyc - irq_at[p - 1]) inside {[4:40]}, 1, "input time");
        repeat (2) @(negedge core_clk);
        check(data_avail, 0, "avail drop");
      end
      slow = p[0];
      for (int a = 0; a < D; a++) put(a[1:0]);
      acc_we = 1'b0;
      if (p == 2)
        dump_long = 1'b1;
      if (p == 4)
      begin
        repeat (30) @(negedge core_clk);
        ref_tick = 1'b1;
        t0 = cyc;
      end
      while (dump_irq !== 1'b1) @(negedge core_clk);
      irq_at[p] = cyc;
      check(n_got, NW * p, "words per dump");
      ref_tick = 1'b0;
      exp_q = {exp_q, pend};
      pend = {};
      check(data_avail, 1, "avail");
      check(bank_sel, {~p[0]}, "bank swap");
    end
    check(irq_at[1] - irq_at[0], 100, "short period");
    check(irq_at[3] - irq_at[2], 200, "long period");
    check((cyc - t0) inside {[2:6]}, 1, "tick restart");
    while (exp_q.size() != 0) @(negedge core_clk);
    check((cyc - irq_at[4]) inside {[4:40]}, 1, "input time");
    // Host gives up on the next dump: done alone must drop the indication
    quit = 1'b1;
    while (dump_irq !== 1'b1) @(negedge core_clk);
    check(n_got, NW * 5, "words per dump");
    check(data_avail, 1, "avail");
    @(negedge core_clk);
    check(dump_irq, 0, "irq one cycle");
    check(data_avail, 0, "avail on done");
    check(sum_got[0], sum_exp[0], "even dumps");
    check(sum_got[1], sum_exp[1], "odd dumps");
    summarize();
  end
endmodule // tb_cdt_dump
`default_nettype wire
